// file: hw/pts_edge_det.sv
// edge detector for one trigger channel
module pts_edge_det (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // selected source
    input  wire logic level,
    input  wire logic rise_sel,
    input  wire logic enable,
    input  wire logic restart,
    // start pulse
    output logic      pulse
);

    typedef struct packed {
        logic prev;
        logic primed;
        logic pulse;
    } pts_edge_s;

    pts_edge_s st_q;
    pts_edge_s st_d;

    // history is dropped on a new selection so the swap itself never fires
    always_comb
    begin
        st_d        = st_q;
        st_d.prev   = level;
        st_d.primed = !restart;                                                      // [R15]
        st_d.pulse  = enable && st_q.primed && !restart &&
                      (rise_sel ? (level && !st_q.prev) : (!level && st_q.prev));    // [R14]
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign pulse = st_q.pulse;

    // ********************************************************
    // checks
    // ********************************************************
    a_edge_single_pulse: assert property (@(posedge clk) disable iff (rst) pulse |=> !pulse) // [R14]
        else $error("trigger pulse lasted more than one cycle");

endmodule

// file: hw/pts_trigger_select.sv
// trigger source selection for two converters and three serial ports
// Operation
// R01 - all three converter groups take external events
// R02 - each group: own source and polarity
// R03 - converter one source code decode table
// R04 - converter two: code zero uses own pin
// R05 - sources usable even when pin unbonded
// R06 - software drives pin triggers, input or output; here no register drives a pin, all pins are inputs only
// R07 - rising polarity fires on compare assertion
// R08 - falling polarity fires on compare release
// R09 - four bit select, zero disables group
// R10 - codes one to eight: port a pins
// R11 - codes nine to fourteen timers, fifteen tick
// R12 - tick counter fires periodically
// R13 - transfer groups triggered independently
// R14 - synchronise, one cycle pulse on edge
// R15 - selection change gives no spurious pulse
//
// The plain strobed port and the address map were decided locally.
module pts_trigger_select #(
    parameter int TG_COUNT = 4
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // register port
    input  wire logic [pts_pkg::ADDR_W-1:0] addr,
    input  wire logic [pts_pkg::DATA_W-1:0] wdata,
    input  wire logic                     wr_stb,
    input  wire logic                     rd_stb,
    output logic [pts_pkg::DATA_W-1:0]    rdata,
    // trigger sources
    input  wire logic                     conv1_external_event_pin,
    input  wire logic                     conv2_external_event_pin,
    input  wire logic [7:0]               port_a_pin,
    input  wire logic [1:0]               port_b_pin,
    input  wire logic [19:0]              timer_channel,
    input  wire logic                     realtime_interrupt_compare,
    // start pulses
    output logic [2:0]                    conv1_trigger,
    output logic [2:0]                    conv2_trigger,
    output logic [TG_COUNT-1:0]           sp1_trigger,
    output logic [TG_COUNT-1:0]           sp3_trigger,
    output logic [TG_COUNT-1:0]           sp5_trigger
);

    localparam int SPW   = pts_pkg::SP_FIELD_W * TG_COUNT;
    localparam int NSP   = 3 * TG_COUNT;
    localparam int NCH   = 6 + NSP;

    typedef struct packed {
        logic [1:0][pts_pkg::CONV_CTRL_W-1:0] conv_ctrl;
        logic [2:0][SPW-1:0]                  sp_sel;
        logic [2:0][pts_pkg::TICK_W-1:0]      tick_per;
        logic [2:0][pts_pkg::TICK_W-1:0]      tick_cnt;
        logic [2:0]                           tick;
        logic [pts_pkg::N_PIN-1:0]            s1;
        logic [pts_pkg::N_PIN-1:0]            s2;
        logic [pts_pkg::N_PIN-1:0]            s3;
        logic [pts_pkg::N_PIN-1:0]            filt;
        logic [NCH-1:0]                       seen;
        logic [pts_pkg::DATA_W-1:0]           rdata;
    } pts_state_s;

    pts_state_s q;
    pts_state_s d;

    logic [pts_pkg::N_PIN-1:0] pin_raw;
    logic [pts_pkg::N_PIN-1:0] agree;
    logic [NCH-1:0]            trig;
    logic [5:0]                conv_lvl;
    logic [NSP-1:0]            sp_lvl;

    // ********************************************************
    // source decode
    // ********************************************************
    function automatic logic conv_pick(input logic [2:0] sel, input logic own_pin,
                                       input logic [pts_pkg::N_PIN-1:0] f, input logic rtic);
        logic r;
        r = 1'b0;
        case (sel)
            pts_pkg::CONV_SRC_PIN:  r = own_pin;                                    // [R04]
            pts_pkg::CONV_SRC_T8:   r = f[pts_pkg::PIN_T8];                         // [R03]
            pts_pkg::CONV_SRC_T10:  r = f[pts_pkg::PIN_T10];
            pts_pkg::CONV_SRC_RTIC: r = rtic;                                       // [R07]
            pts_pkg::CONV_SRC_T17:  r = f[pts_pkg::PIN_T17];
            pts_pkg::CONV_SRC_T19:  r = f[pts_pkg::PIN_T19];
            pts_pkg::CONV_SRC_PB0:  r = f[pts_pkg::PIN_PB0];
            pts_pkg::CONV_SRC_PB1:  r = f[pts_pkg::PIN_PB1];
            default:                r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic sp_pick(input logic [3:0] sel, input logic [pts_pkg::N_PIN-1:0] f,
                                     input logic tick);
        logic r;
        r = 1'b0;
        if (sel >= pts_pkg::SP_SRC_PA0 && sel <= pts_pkg::SP_SRC_PA7)
            r = f[pts_pkg::PIN_PA0 + int'(sel) - 1];                                // [R10]
        else
        begin
            case (sel)
                pts_pkg::SP_SRC_T8:   r = f[pts_pkg::PIN_T8];                       // [R11]
                pts_pkg::SP_SRC_T10:  r = f[pts_pkg::PIN_T10];
                pts_pkg::SP_SRC_T12:  r = f[pts_pkg::PIN_T12];
                pts_pkg::SP_SRC_T14:  r = f[pts_pkg::PIN_T14];
                pts_pkg::SP_SRC_T16:  r = f[pts_pkg::PIN_T16];
                pts_pkg::SP_SRC_T18:  r = f[pts_pkg::PIN_T18];
                pts_pkg::SP_SRC_TICK: r = tick;                                     // [R12]
                default:              r = 1'b0;                                     // [R09]
            endcase
        end
        return r;
    endfunction

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    // every source is wired in whether or not its pad is bonded
    assign pin_raw = {timer_channel[19], timer_channel[18], timer_channel[17], timer_channel[16],
                      timer_channel[14], timer_channel[12], timer_channel[10], timer_channel[8],
                      port_b_pin, port_a_pin, conv2_external_event_pin,
                      conv1_external_event_pin};                                    // [R05]
    assign agree   = q.s2 ~^ q.s3;

    // ********************************************************
    // state update
    // ********************************************************
    always_comb
    begin
        d       = q;
        d.s1    = pin_raw;                                                          // [R14]
        d.s2    = q.s1;
        d.s3    = q.s2;
        d.filt  = (agree & q.s3) | (~agree & q.filt);                               // [R14]
        d.rdata = '0;

        // register writes
        if (wr_stb)
        begin
            case (addr)
                pts_pkg::ADDR_CONV1: d.conv_ctrl[0] = wdata[pts_pkg::CONV_CTRL_W-1:0]; // [R02]
                pts_pkg::ADDR_CONV2: d.conv_ctrl[1] = wdata[pts_pkg::CONV_CTRL_W-1:0];
                pts_pkg::ADDR_SP1:   d.sp_sel[0]    = wdata[SPW-1:0];                  // [R09]
                pts_pkg::ADDR_SP3:   d.sp_sel[1]    = wdata[SPW-1:0];
                pts_pkg::ADDR_SP5:   d.sp_sel[2]    = wdata[SPW-1:0];
                pts_pkg::ADDR_TICK1: d.tick_per[0]  = wdata[pts_pkg::TICK_W-1:0];
                pts_pkg::ADDR_TICK3: d.tick_per[1]  = wdata[pts_pkg::TICK_W-1:0];
                pts_pkg::ADDR_TICK5: d.tick_per[2]  = wdata[pts_pkg::TICK_W-1:0];
                default:             d.rdata        = '0;
            endcase
        end

        // periodic tick per serial port, period zero stops it
        for (int p = 0; p < 3; p++)
        begin
            d.tick[p] = 1'b0;
            if (q.tick_per[p] == pts_pkg::TICK_PER_RST)
                d.tick_cnt[p] = '0;
            else if (q.tick_cnt[p] == '0)
            begin
                d.tick[p]     = 1'b1;                                               // [R12]
                d.tick_cnt[p] = q.tick_per[p] - 16'h0001;
            end
            else
                d.tick_cnt[p] = q.tick_cnt[p] - 16'h0001;
        end

        // sticky seen flags, a new pulse beats a clear in the same cycle
        if (wr_stb && addr == pts_pkg::ADDR_SEEN)
            d.seen = q.seen & ~wdata[NCH-1:0];
        d.seen = d.seen | trig;

        // read data, valid only in the cycle after the strobe
        if (rd_stb)
        begin
            case (addr)
                pts_pkg::ADDR_CONV1: d.rdata = 32'(q.conv_ctrl[0]);
                pts_pkg::ADDR_CONV2: d.rdata = 32'(q.conv_ctrl[1]);
                pts_pkg::ADDR_SP1:   d.rdata = 32'(q.sp_sel[0]);
                pts_pkg::ADDR_SP3:   d.rdata = 32'(q.sp_sel[1]);
                pts_pkg::ADDR_SP5:   d.rdata = 32'(q.sp_sel[2]);
                pts_pkg::ADDR_TICK1: d.rdata = 32'(q.tick_per[0]);
                pts_pkg::ADDR_TICK3: d.rdata = 32'(q.tick_per[1]);
                pts_pkg::ADDR_TICK5: d.rdata = 32'(q.tick_per[2]);
                pts_pkg::ADDR_LEVEL: d.rdata = 32'(q.filt);
                pts_pkg::ADDR_SEEN:  d.rdata = 32'(q.seen);
                default:             d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q              <= '0;
            q.conv_ctrl[0] <= pts_pkg::CONV_CTRL_RST;
            q.conv_ctrl[1] <= pts_pkg::CONV_CTRL_RST;
            q.tick_per     <= {3{pts_pkg::TICK_PER_RST}};
            q.sp_sel       <= {(3 * TG_COUNT){pts_pkg::SP_SEL_RST}};
        end
        else
            q <= d;
    end

    // ********************************************************
    // converter channels
    // ********************************************************
    // channel c: converter c/3, group c%3 (group 1, group 2, event group)
    for (genvar c = 0; c < 6; c++)
    begin : g_conv
        localparam int CV  = c / 3;
        localparam int LSB = (c % 3) * pts_pkg::CONV_FIELD_W;
        logic [3:0] fld_q;
        logic [3:0] fld_d;
        assign fld_q       = q.conv_ctrl[CV][LSB +: pts_pkg::CONV_FIELD_W];         // [R02]
        assign fld_d       = d.conv_ctrl[CV][LSB +: pts_pkg::CONV_FIELD_W];
        assign conv_lvl[c] = conv_pick(fld_q[pts_pkg::CONV_SEL_LSB +: 3],
                                       (CV == 0) ? q.filt[pts_pkg::PIN_CONV1] : q.filt[pts_pkg::PIN_CONV2],
                                       q.filt, realtime_interrupt_compare);         // [R03] [R04]
        pts_edge_det u_edge (
            .clk      (clk),
            .rst      (rst),
            .level    (conv_lvl[c]),
            .rise_sel (fld_q[pts_pkg::CONV_POL_BIT]),                               // [R07] [R08]
            .enable   (1'b1),                                                       // [R01]
            .restart  (fld_d != fld_q),                                             // [R15]
            .pulse    (trig[c])
        );
    end

    // ********************************************************
    // serial port transfer group channels
    // ********************************************************
    // each transfer group of each port is its own channel
    for (genvar k = 0; k < NSP; k++)
    begin : g_sp
        localparam int PORT = k / TG_COUNT;
        localparam int LSB  = (k % TG_COUNT) * pts_pkg::SP_FIELD_W;
        logic [3:0] sel_q;
        logic [3:0] sel_d;
        assign sel_q     = q.sp_sel[PORT][LSB +: pts_pkg::SP_FIELD_W];              // [R13]
        assign sel_d     = d.sp_sel[PORT][LSB +: pts_pkg::SP_FIELD_W];
        assign sp_lvl[k] = sp_pick(sel_q, q.filt, q.tick[PORT]);                    // [R10] [R11]
        pts_edge_det u_edge (
            .clk      (clk),
            .rst      (rst),
            .level    (sp_lvl[k]),
            .rise_sel (1'b1),
            .enable   (sel_q != pts_pkg::SP_SRC_OFF),                               // [R09]
            .restart  (sel_d != sel_q),                                             // [R15]
            .pulse    (trig[6 + k])
        );
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign rdata         = q.rdata;
    assign conv1_trigger = trig[2:0];
    assign conv2_trigger = trig[5:3];
    assign sp1_trigger   = trig[6 +: TG_COUNT];
    assign sp3_trigger   = trig[6 + TG_COUNT +: TG_COUNT];
    assign sp5_trigger   = trig[6 + 2 * TG_COUNT +: TG_COUNT];

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_conv_rise_edge: assert property (conv1_trigger[0] && $past(q.conv_ctrl[0][3])    // [R07]
        |-> $past(conv_lvl[0]) && !$past(conv_lvl[0], 2))
        else $error("rising trigger without rising source");
    a_conv_fall_edge: assert property (conv2_trigger[1] && !$past(q.conv_ctrl[1][7])   // [R08]
        |-> !$past(conv_lvl[4]) && $past(conv_lvl[4], 2))
        else $error("falling trigger without falling source");
    a_conv1_own_pin: assert property (q.conv_ctrl[0][2:0] == pts_pkg::CONV_SRC_PIN     // [R03]
        |-> conv_lvl[0] == q.filt[pts_pkg::PIN_CONV1])
        else $error("converter one code zero not routed to its pin");
    a_conv2_own_pin: assert property (q.conv_ctrl[1][2:0] == pts_pkg::CONV_SRC_PIN     // [R04]
        |-> conv_lvl[3] == q.filt[pts_pkg::PIN_CONV2])
        else $error("converter two code zero not routed to its pin");
    a_conv_rtic_route: assert property (q.conv_ctrl[0][6:4] == pts_pkg::CONV_SRC_RTIC  // [R03]
        |-> conv_lvl[1] == realtime_interrupt_compare)
        else $error("compare source not routed");
    a_sp_disabled_quiet: assert property (sp1_trigger[0]                                // [R09]
        |-> $past(q.sp_sel[0][3:0]) != pts_pkg::SP_SRC_OFF)
        else $error("disabled transfer group triggered");
    a_sp_port_a_route: assert property (q.sp_sel[1][3:0] == pts_pkg::SP_SRC_PA0 + 4'h3 // [R10]
        |-> sp_lvl[TG_COUNT] == q.filt[pts_pkg::PIN_PA0 + 3])
        else $error("port a pin three not routed");
    a_sp_timer_route: assert property (q.sp_sel[2][3:0] == pts_pkg::SP_SRC_T8          // [R11]
        |-> sp_lvl[2 * TG_COUNT] == q.filt[pts_pkg::PIN_T8])
        else $error("timer channel eight not routed");
    a_tick_reload: assert property (q.tick[0] && $stable(q.tick_per[0])                 // [R12]
        |-> q.tick_cnt[0] == q.tick_per[0] - 16'h0001)
        else $error("tick counter not reloaded with period");
    a_select_quiet: assert property ($changed(q.conv_ctrl[0][3:0]) |=> !conv1_trigger[0]) // [R15]
        else $error("selection change produced a trigger");
    a_pin_filter: assert property ($changed(q.filt[pts_pkg::PIN_CONV1])                 // [R14]
        |-> $past(q.s2[pts_pkg::PIN_CONV1] == q.s3[pts_pkg::PIN_CONV1]))
        else $error("filtered pin changed before stages agreed");

    // further routing, sticky record and tick checks
    a_conv_t19_route: assert property (q.conv_ctrl[0][2:0] == pts_pkg::CONV_SRC_T19   // [R03]
        |-> conv_lvl[0] == q.filt[pts_pkg::PIN_T19])
        else $error("timer channel nineteen not routed");

    a_conv_pb_route: assert property (q.conv_ctrl[1][10:8] == pts_pkg::CONV_SRC_PB1   // [R03]
        |-> conv_lvl[5] == q.filt[pts_pkg::PIN_PB1])
        else $error("port b pin one not routed");

    a_sp_off_level: assert property (q.sp_sel[2][3:0] == pts_pkg::SP_SRC_OFF          // [R09]
        |-> !sp_lvl[2 * TG_COUNT])
        else $error("disabled transfer group sees a source");

    a_sp_pa7_route: assert property (q.sp_sel[0][3:0] == pts_pkg::SP_SRC_PA7          // [R10]
        |-> sp_lvl[0] == q.filt[pts_pkg::PIN_PA0 + 7])
        else $error("port a pin seven not routed");

    a_sp_t18_route: assert property (q.sp_sel[1][3:0] == pts_pkg::SP_SRC_T18          // [R11]
        |-> sp_lvl[TG_COUNT] == q.filt[pts_pkg::PIN_T18])
        else $error("timer channel eighteen not routed");

    a_sp_tick_route: assert property (q.sp_sel[0][7:4] == pts_pkg::SP_SRC_TICK        // [R12]
        |-> sp_lvl[1] == q.tick[0])
        else $error("tick not routed to transfer group");

    a_tick_stopped: assert property (q.tick_per[1] == pts_pkg::TICK_PER_RST           // [R12]
        |=> !q.tick[1])
        else $error("tick ran with period zero");

    a_seen_sticky_set: assert property (trig[2] |=> q.seen[2])                        // [R01]
        else $error("event group pulse not recorded");

    c_rtic_fall: cover property (conv1_trigger[0] && !$past(q.conv_ctrl[0][3])
        && $past(q.conv_ctrl[0][2:0]) == pts_pkg::CONV_SRC_RTIC);
    c_sp_tick: cover property (sp1_trigger[0] && $past(q.sp_sel[0][3:0]) == pts_pkg::SP_SRC_TICK);
    c_sp5_port_a: cover property (sp5_trigger[TG_COUNT-1]);
    c_sp3_port_a: cover property (sp3_trigger[0]);
    c_conv2_fall: cover property (conv2_trigger[1] && !$past(q.conv_ctrl[1][7]));

endmodule

// file: inc/pts_pkg.sv
// shared constants of the peripheral trigger select block
package pts_pkg;

    // ********************************************************
    // register bus
    // ********************************************************
    localparam int          DATA_W      = 32;
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  ADDR_CONV1  = 4'h0;
    localparam logic [3:0]  ADDR_CONV2  = 4'h1;
    localparam logic [3:0]  ADDR_SP1    = 4'h2;
    localparam logic [3:0]  ADDR_SP3    = 4'h3;
    localparam logic [3:0]  ADDR_SP5    = 4'h4;
    localparam logic [3:0]  ADDR_TICK1  = 4'h5;
    localparam logic [3:0]  ADDR_TICK3  = 4'h6;
    localparam logic [3:0]  ADDR_TICK5  = 4'h7;
    localparam logic [3:0]  ADDR_LEVEL  = 4'h8;
    localparam logic [3:0]  ADDR_SEEN   = 4'h9;

    // ********************************************************
    // field layout and reset values
    // ********************************************************
    localparam int          CONV_FIELD_W   = 4;
    localparam int          CONV_SEL_LSB   = 0;
    localparam int          CONV_POL_BIT   = 3;
    localparam int          CONV_CTRL_W    = 12;
    localparam int          SP_FIELD_W     = 4;
    localparam int          TICK_W         = 16;
    localparam logic [11:0] CONV_CTRL_RST  = 12'h888;
    localparam logic [3:0]  SP_SEL_RST     = 4'h0;
    localparam logic [15:0] TICK_PER_RST   = 16'h0000;

    // ********************************************************
    // converter source codes
    // ********************************************************
    localparam logic [2:0]  CONV_SRC_PIN   = 3'h0;
    localparam logic [2:0]  CONV_SRC_T8    = 3'h1;
    localparam logic [2:0]  CONV_SRC_T10   = 3'h2;
    localparam logic [2:0]  CONV_SRC_RTIC  = 3'h3;
    localparam logic [2:0]  CONV_SRC_T17   = 3'h4;
    localparam logic [2:0]  CONV_SRC_T19   = 3'h5;
    localparam logic [2:0]  CONV_SRC_PB0   = 3'h6;
    localparam logic [2:0]  CONV_SRC_PB1   = 3'h7;

    // ********************************************************
    // serial port source codes
    // ********************************************************
    localparam logic [3:0]  SP_SRC_OFF     = 4'h0;
    localparam logic [3:0]  SP_SRC_PA0     = 4'h1;
    localparam logic [3:0]  SP_SRC_PA7     = 4'h8;
    localparam logic [3:0]  SP_SRC_T8      = 4'h9;
    localparam logic [3:0]  SP_SRC_T10     = 4'ha;
    localparam logic [3:0]  SP_SRC_T12     = 4'hb;
    localparam logic [3:0]  SP_SRC_T14     = 4'hc;
    localparam logic [3:0]  SP_SRC_T16     = 4'hd;
    localparam logic [3:0]  SP_SRC_T18     = 4'he;
    localparam logic [3:0]  SP_SRC_TICK    = 4'hf;

    // ********************************************************
    // synchronised pin vector positions
    // ********************************************************
    localparam int          PIN_CONV1      = 0;
    localparam int          PIN_CONV2      = 1;
    localparam int          PIN_PA0        = 2;
    localparam int          PIN_PB0        = 10;
    localparam int          PIN_PB1        = 11;
    localparam int          PIN_T8         = 12;
    localparam int          PIN_T10        = 13;
    localparam int          PIN_T12        = 14;
    localparam int          PIN_T14        = 15;
    localparam int          PIN_T16        = 16;
    localparam int          PIN_T17        = 17;
    localparam int          PIN_T18        = 18;
    localparam int          PIN_T19        = 19;
    localparam int          N_PIN          = 20;

endpackage

// file: sim/pts_src_model.sv
// behavioural model of the timer, port and compare event sources
module pts_src_model (
    // clock
    input  wire logic        clk,
    // bench control
    input  wire logic [4:0]  src,
    input  wire logic        lvl,
    // event sources
    output logic             conv1_external_event_pin,
    output logic             conv2_external_event_pin,
    output logic [7:0]       port_a_pin,
    output logic [1:0]       port_b_pin,
    output logic [19:0]      timer_channel,
    output logic             realtime_interrupt_compare
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [20:0] v;
    logic        nz = 1'b0;
    // the chosen source follows the level software sets, the rest rest low
    always_comb
    begin
        v = '0;
        v[src] = lvl;
    end
    // unused timer channels toggle so they never look settled
    always_ff @(posedge clk) nz <= ~nz;
    assign conv1_external_event_pin   = v[0];
    assign conv2_external_event_pin   = v[1];
    assign port_a_pin                 = v[9:2];
    assign port_b_pin                 = v[11:10];
    assign timer_channel              = {v[19:16], nz, v[15], nz, v[14], nz, v[13], nz, v[12], {8{nz}}};
    assign realtime_interrupt_compare = v[20];
endmodule

// file: sim/pts_trigger_select_tb_top.sv
// self-checking testbench of the trigger select block
module pts_trigger_select_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = '0;
    logic [31:0] wdata = '0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [31:0] rdata;
    logic [4:0]  src = '0;
    logic        lvl = 1'b0;
    logic        p1, p2, rtc;
    logic [7:0]  pa;
    logic [1:0]  pb;
    logic [19:0] tm;
    logic [2:0]  c1t, c2t;
    logic [3:0]  s1t, s3t, s5t;
    logic [17:0] outs;
    int          failures = 0;
    int          checks = 0;
    int          seed = 32'h0972_2e4a;
    int          tmap [6] = '{12, 13, 14, 15, 16, 18};
    assign outs = {s5t, s3t, s1t, c2t, c1t};

    pts_src_model mdl (.clk(clk), .src(src), .lvl(lvl), .conv1_external_event_pin(p1),
        .conv2_external_event_pin(p2), .port_a_pin(pa), .port_b_pin(pb), .timer_channel(tm),
        .realtime_interrupt_compare(rtc));
    pts_trigger_select #(.TG_COUNT(4)) uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .conv1_external_event_pin(p1),
        .conv2_external_event_pin(p2), .port_a_pin(pa), .port_b_pin(pb), .timer_channel(tm),
        .realtime_interrupt_compare(rtc), .conv1_trigger(c1t), .conv2_trigger(c2t),
        .sp1_trigger(s1t), .sp3_trigger(s3t), .sp5_trigger(s5t));

    initial
    begin
        forever #50 clk = ~clk;
    end

    // ********************************************************
    // expectations and bus tasks
    // ********************************************************
    function automatic int conv_src(input int cv, input int code);
        int m [8] = '{0, 12, 13, 20, 17, 19, 10, 11};
        return (code == 0) ? cv : m[code];
    endfunction
    function automatic int sp_src(input int code);
        return (code <= 8) ? code + 1 : tmap[code-9];
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 check(rdata, e);
    endtask
    task automatic count(input int sel, input int n, output int c);
        c = 0;
        repeat (n)
        begin
            @(posedge clk);
            #1 if (outs[sel] === 1'b1) c++;
        end
    endtask
    task automatic fire(input int s, input int sel, input logic [3:0] a, input logic [31:0] d,
                        input logic rise, input int e);
        int c, n;
        @(posedge clk);
        lvl <= rise;
        src <= 5'(s);
        repeat (8) @(posedge clk);
        wr(a, d);
        count(sel, 8, c);
        check(32'(c), 0);
        @(posedge clk);
        lvl <= ~rise;
        count(sel, 8, n);
        @(posedge clk);
        lvl <= rise;
        count(sel, 12, c);
        check(32'(c + n), 32'(e));
    endtask
    task automatic summarize();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ********************************************************
    // scenarios
    // ********************************************************
    initial
    begin
        int g, c;
        logic [31:0] d;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(pts_pkg::ADDR_CONV1, 32'h0000_0888);
        rd(pts_pkg::ADDR_SP3, 32'h0000_0000);
        wr(4'hc, 32'hffff_ffff);
        rd(4'hc, 32'h0000_0000);
        for (int cv = 0; cv < 2; cv++)
            for (int code = 0; code < 8; code++)
                for (int pol = 0; pol < 2; pol++)
                begin
                    g = int'($unsigned($random(seed)) % 3);
                    d = (32'h0000_0888 & ~(32'hf << (4 * g))) | (32'(pol * 8 + code) << (4 * g));
                    fire(conv_src(cv, code), cv * 3 + g, 4'(cv), d, pol[0], 1);
                    rd(4'(cv), d);
                end
        for (int p = 0; p < 3; p++)
            for (int code = 0; code < 15; code++)
            begin
                g = int'($unsigned($random(seed)) % 4);
                fire(sp_src(code), 6 + 4 * p + g, 4'(2 + p), 32'(code) << (4 * g), 1'b1, int'(code != 0));
            end
        fire(20, 4, pts_pkg::ADDR_CONV2, 32'h0000_0838, 1'b0, 1);
        fire(5, 10, pts_pkg::ADDR_SP3, 32'h0000_0004, 1'b1, 1);
        fire(12, 14, pts_pkg::ADDR_SP5, 32'h0000_0009, 1'b1, 1);
        wr(pts_pkg::ADDR_TICK1, 32'h0000_0005);
        wr(pts_pkg::ADDR_SP1, 32'h0000_00f0);
        repeat (10) @(posedge clk);
        count(7, 50, c);
        check(32'(c), 10);
        wr(pts_pkg::ADDR_SP1, 32'h0000_0000);
        repeat (4) @(posedge clk);
        count(7, 20, c);
        check(32'(c), 0);
        summarize();
    end

    initial
    begin
        #(30000 * 100);
        failures++;
        summarize();
    end
endmodule
